// [src/sc_cmd_pkg.sv]
package sc_cmd_pkg;

  // Clock rate.
  localparam int CLK_HZ = 20_000_000;

  // Bus command codes, one per word command.
  localparam logic [7:0] CMD_VENDOR = 8'h00;
  localparam logic [7:0] CMD_TEMP   = 8'h08;
  localparam logic [7:0] CMD_VOLT   = 8'h09;
  localparam logic [7:0] CMD_CURR   = 8'h0A;
  localparam logic [7:0] CMD_ESR    = 8'h0B;
  localparam logic [7:0] CMD_RSOC   = 8'h0D;
  localparam logic [7:0] CMD_HEALTH = 8'h0E;

  // Sub-command codes written to the vendor command port.
  localparam logic [15:0] SUB_DEV_TYPE  = 16'h0001;
  localparam logic [15:0] SUB_FW_REV    = 16'h0002;
  localparam logic [15:0] SUB_HW_REV    = 16'h0003;
  localparam logic [15:0] SUB_CKSUM     = 16'h0004;
  localparam logic [15:0] SUB_SEAL      = 16'h0020;
  localparam logic [15:0] SUB_LIFE_BAL  = 16'h0021;
  localparam logic [15:0] SUB_ALARM_SET = 16'h0030;
  localparam logic [15:0] SUB_ALARM_CLR = 16'h0031;
  localparam logic [15:0] SUB_CL0_SET   = 16'h0032;
  localparam logic [15:0] SUB_CL0_CLR   = 16'h0033;
  localparam logic [15:0] SUB_CL1_SET   = 16'h0034;
  localparam logic [15:0] SUB_CL1_CLR   = 16'h0035;
  localparam logic [15:0] SUB_LL_SET    = 16'h0037;
  localparam logic [15:0] SUB_LL_CLR    = 16'h0038;
  localparam logic [15:0] SUB_CAL       = 16'h0040;
  localparam logic [15:0] SUB_RESET     = 16'h0041;

  // Identity and key words; the values are arbitrary.
  localparam logic [15:0] DEV_TYPE_ID = 16'h5A01;
  localparam logic [15:0] FW_REV_ID   = 16'h0100;
  localparam logic [15:0] KEY_WORD1   = 16'h1234;
  localparam logic [15:0] KEY_WORD2   = 16'h5678;

  // Parameter store shape and the reserved word holding the revision.
  localparam int          PS_DEPTH   = 32;
  localparam int          PS_AW      = 5;
  localparam logic [4:0]  HW_REV_IDX = 5'h1F;

  // Measurement limits.
  localparam logic [15:0] VOLT_MAX_MV = 16'd20000;
  localparam logic [7:0]  PCT_FULL    = 8'd100;
  localparam logic [7:0]  PCT_HOLD    = 8'd99;
  localparam logic [6:0]  PCT_SCALE   = 7'd100;
  localparam logic [4:0]  DIV_STEPS   = 5'd23;

  // Times and derived cycle counts.
  localparam int UNSEAL_WAIT_S   = 4;
  localparam int UNSEAL_WAIT_CYC = CLK_HZ * UNSEAL_WAIT_S;
  localparam int RESET_HOLD_MS   = 2;
  localparam int RESET_HOLD_CYC  = (CLK_HZ / 1000) * RESET_HOLD_MS;
  localparam int LOCK_W          = 27;
  localparam int HOLD_W          = 16;

  // Value after reset of the sealed flag.
  localparam logic SEALED_RST = 1'b1;

  typedef logic [LOCK_W-1:0] lock_cnt_t;
  typedef logic [HOLD_W-1:0] hold_cnt_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_CKSUM    = 3'b010,
    ST_RST_HOLD = 3'b100
  } ctrl_state_t;

endpackage : sc_cmd_pkg

// [src/pct_ceil.sv]
// Free-running ceiling percentage: pct = ceil(numer * 100 / denom),
// saturated at 100, zero when denom is zero. A new result every 24 cycles.
module pct_ceil (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Operands
  input  wire logic [15:0] numer,
  input  wire logic [15:0] denom,
  // Result
  output logic      [7:0]  pct
);

  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] rem_q, rem_d;
  logic [22:0] quo_q, quo_d;
  logic [15:0] den_q, den_d;
  logic [7:0]  pct_q, pct_d;
  logic [16:0] trial;
  logic [16:0] diff;
  logic        fits;
  logic [22:0] quo_n;
  logic [15:0] rem_n;
  logic [22:0] ceil_q;

  always_comb begin
    cnt_d  = cnt_q;
    rem_d  = rem_q;
    quo_d  = quo_q;
    den_d  = den_q;
    pct_d  = pct_q;
    trial  = {rem_q, quo_q[22]};
    diff   = trial - {1'b0, den_q};
    fits   = (trial >= {1'b0, den_q});
    quo_n  = {quo_q[21:0], fits};
    rem_n  = fits ? diff[15:0] : trial[15:0];
    ceil_q = quo_n + {22'h000000, (rem_n != 16'h0000)};
    if (cnt_q == 5'h00) begin
      quo_d = 23'(numer) * 23'(sc_cmd_pkg::PCT_SCALE);
      rem_d = 16'h0000;
      den_d = denom;
      cnt_d = sc_cmd_pkg::DIV_STEPS;
    end else begin
      quo_d = quo_n;
      rem_d = rem_n;
      cnt_d = cnt_q - 5'h01;
      // R19 round fraction up
      if (cnt_q == 5'h01) begin
        if (den_q == 16'h0000) begin
          pct_d = 8'h00;
        end else if (ceil_q > {15'h0000, sc_cmd_pkg::PCT_FULL}) begin
          pct_d = sc_cmd_pkg::PCT_FULL;
        end else begin
          pct_d = ceil_q[7:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 5'h00;
      rem_q <= 16'h0000;
      quo_q <= 23'h000000;
      den_q <= 16'h0000;
      pct_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
      rem_q <= rem_d;
      quo_q <= quo_d;
      den_q <= den_d;
      pct_q <= pct_d;
    end
  end

  assign pct = pct_q;

endmodule : pct_ceil

// [src/supercap_cmd.sv]
// Summary of operation
// R1: Hardware revision from reserved store byte.
// R2: Checksum only when unsealed, ready promptly.
// R3: Commands during checksum never abort it.
// R4: Seal sets flag, only when unsealed.
// R5: Lifetime/balancing sub-command controls both features.
// R6: Alarm set drives pin high, clear low.
// R7: Charge level 0 set high, clear low.
// R8: Learn load set high, clear low.
// R9: Pin, calibration, reset commands need unsealed.
// R10: Reset holds bus clock low, then completes.
// R11: After reset discharge if target below stack.
// R12: Two key words in order unseal device.
// R13: Failed unseal locks out four seconds.
// R14: Write sub-command, then read vendor port.
// R15: Temperature word, source chosen by select bits.
// R16: Stack voltage in millivolts, 0 to 20000.
// R17: Signed current, deadband reported as zero.
// R18: Series resistance word in milliohms.
// R19: Relative charge percent, fractions rounded up.
// R20: Hold-at-99 set: 99 until termination.
// R21: Hold-at-99 clear: above 99 shows 100.
// R22: Health percent of initial, rounded up.
// R23: Write 1 enables, 0 disables both.
// R24: Charge level 1 codes are parameters.
module supercap_cmd #(
  parameter int          UNSEAL_WAIT_CYC = sc_cmd_pkg::UNSEAL_WAIT_CYC,
  parameter int          RESET_HOLD_CYC  = sc_cmd_pkg::RESET_HOLD_CYC,
  parameter logic [15:0] CL1_SET_CODE    = sc_cmd_pkg::SUB_CL1_SET,
  parameter logic [15:0] CL1_CLR_CODE    = sc_cmd_pkg::SUB_CL1_CLR
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Word commands from the bus transaction layer
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic      [15:0] rsp_data,
  // Bus clock line hold, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  // Parameter store loading
  input  wire logic        ps_wr_en,
  input  wire logic [4:0]  ps_wr_addr,
  input  wire logic [15:0] ps_wr_data,
  // Measurements and configuration
  input  wire logic [15:0] temp_internal,
  input  wire logic [15:0] temp_ext_a,
  input  wire logic [15:0] temp_ext_b,
  input  wire logic        temp_source_sel_hi,
  input  wire logic        temp_source_sel_lo,
  input  wire logic [15:0] stack_top_sense_input,
  input  wire logic [15:0] current_raw,
  input  wire logic [15:0] deadband_ma,
  input  wire logic [15:0] esr_mohm,
  input  wire logic [15:0] remaining_cap,
  input  wire logic [15:0] full_cap,
  input  wire logic [15:0] present_cap,
  input  wire logic [15:0] initial_cap_value,
  input  wire logic        hold_at_99_enable,
  input  wire logic        charge_term,
  input  wire logic [15:0] target_charge_voltage,
  // Pins and state
  output logic             alarm_out,
  output logic             charge_level_select0,
  output logic             charge_level_select1,
  output logic             learn_load_drive,
  output logic             lifetime_log_enable,
  output logic             balance_enable,
  output logic             balance_discharge,
  output logic             cal_mode,
  output logic             sealed
);

  sc_cmd_pkg::ctrl_state_t state_q, state_d;
  logic                  sealed_q, sealed_d, alarm_q, alarm_d;
  logic                  cl0_q, cl0_d, cl1_q, cl1_d, ll_q, ll_d;
  logic                  life_q, life_d, life_arm_q, life_arm_d;
  logic                  cal_q, cal_d, dis_q, dis_d, chk_q, chk_d;
  logic                  key_stage_q, key_stage_d;
  sc_cmd_pkg::lock_cnt_t lock_q, lock_d;
  sc_cmd_pkg::hold_cnt_t hold_q, hold_d;
  logic [15:0]           last_sub_q, last_sub_d;
  logic [4:0]            ck_idx_q, ck_idx_d;
  logic [15:0]           ck_acc_q, ck_acc_d;
  logic [15:0]           ck_sum_q, ck_sum_d;
  logic                  pend_q, pend_d;
  logic                  rsp_valid_q, rsp_valid_d;
  logic [15:0]           rsp_data_q, rsp_data_d;
  logic                  scl_oe_q, scl_oe_d;

  logic [15:0] pstore [sc_cmd_pkg::PS_DEPTH];
  logic [7:0]  rsoc_raw, health_pct, rsoc_pct;
  logic [15:0] temp_word, volt_word, curr_word, curr_mag;
  logic [15:0] vendor_word, read_word;
  logic        vwr, rd, unsealed, ck_busy;

  // R19 relative charge division
  pct_ceil u_rsoc (
    .core_clk (core_clk),
    .rst      (rst),
    .numer    (remaining_cap),
    .denom    (full_cap),
    .pct      (rsoc_raw)
  );

  // R22 health division
  pct_ceil u_health (
    .core_clk (core_clk),
    .rst      (rst),
    .numer    (present_cap),
    .denom    (initial_cap_value),
    .pct      (health_pct)
  );

  // R4 store locked while sealed
  always_ff @(posedge core_clk) begin
    if (ps_wr_en && !sealed_q) begin
      pstore[ps_wr_addr] <= ps_wr_data;
    end
  end

  always_comb begin
    // R15 temperature source select
    case ({temp_source_sel_hi, temp_source_sel_lo})
      2'b00:   temp_word = temp_internal;
      2'b01:   temp_word = temp_ext_a;
      default: temp_word = temp_ext_b;
    endcase
    // R16 clamp stack voltage
    volt_word = (stack_top_sense_input > sc_cmd_pkg::VOLT_MAX_MV) ?
                sc_cmd_pkg::VOLT_MAX_MV : stack_top_sense_input;
    // R17 deadband forces zero
    curr_mag  = current_raw[15] ? (16'h0000 - current_raw) : current_raw;
    curr_word = (curr_mag <= deadband_ma) ? 16'h0000 : current_raw;
    // R20 hold at 99 until termination
    if (hold_at_99_enable && !charge_term &&
        (rsoc_raw == sc_cmd_pkg::PCT_FULL)) begin
      rsoc_pct = sc_cmd_pkg::PCT_HOLD;
    end else begin
      // R21 no hold, rounded value
      rsoc_pct = rsoc_raw;
    end
    // R14 vendor port returns last result
    case (last_sub_q)
      sc_cmd_pkg::SUB_DEV_TYPE: vendor_word = sc_cmd_pkg::DEV_TYPE_ID;
      sc_cmd_pkg::SUB_FW_REV:   vendor_word = sc_cmd_pkg::FW_REV_ID;
      // R1 revision from reserved byte
      sc_cmd_pkg::SUB_HW_REV:
        vendor_word = {8'h00, pstore[sc_cmd_pkg::HW_REV_IDX][7:0]};
      sc_cmd_pkg::SUB_CKSUM:    vendor_word = ck_sum_q;
      sc_cmd_pkg::SUB_LIFE_BAL: vendor_word = {15'h0000, life_q};
      default: vendor_word = {13'h0000, cal_q, ck_busy, sealed_q};
    endcase
    case (cmd_code)
      sc_cmd_pkg::CMD_VENDOR: read_word = vendor_word;
      sc_cmd_pkg::CMD_TEMP:   read_word = temp_word;
      sc_cmd_pkg::CMD_VOLT:   read_word = volt_word;
      sc_cmd_pkg::CMD_CURR:   read_word = curr_word;
      // R18 resistance passed through
      sc_cmd_pkg::CMD_ESR:    read_word = esr_mohm;
      sc_cmd_pkg::CMD_RSOC:   read_word = {8'h00, rsoc_pct};
      sc_cmd_pkg::CMD_HEALTH: read_word = {8'h00, health_pct};
      default:                read_word = 16'hFFFF;
    endcase
  end

  assign vwr      = cmd_valid && cmd_write && (cmd_code == 8'h00);
  assign rd       = cmd_valid && !cmd_write;
  assign unsealed = !sealed_q;
  assign ck_busy  = (state_q == sc_cmd_pkg::ST_CKSUM);

  always_comb begin
    state_d = state_q;
    {sealed_d, alarm_d, cl0_d, cl1_d, ll_d, life_d} =
      {sealed_q, alarm_q, cl0_q, cl1_q, ll_q, life_q};
    {life_arm_d, cal_d, dis_d, key_stage_d, pend_d} =
      {life_arm_q, cal_q, dis_q, key_stage_q, pend_q};
    {hold_d, last_sub_d, ck_idx_d, ck_acc_d, ck_sum_d} =
      {hold_q, last_sub_q, ck_idx_q, ck_acc_q, ck_sum_q};
    {chk_d, rsp_valid_d, rsp_data_d, scl_oe_d} =
      {1'b0, 1'b0, rsp_data_q, scl_oe_q};
    lock_d = (lock_q != '0) ? lock_q - 1'b1 : lock_q;
    // R11 discharge while target below stack
    if (chk_q) begin
      dis_d = (target_charge_voltage < stack_top_sense_input);
    end else if (dis_q &&
                 (target_charge_voltage >= stack_top_sense_input)) begin
      dis_d = 1'b0;
    end

    case (state_q)
      sc_cmd_pkg::ST_RST_HOLD: begin
        // R10 clock held until reset done
        if (hold_q == '0) begin
          scl_oe_d = 1'b0;
          chk_d    = 1'b1;
          state_d  = sc_cmd_pkg::ST_IDLE;
        end else begin
          hold_d = hold_q - 1'b1;
        end
      end
      default: begin
        // R3 checksum runs to the end
        if (ck_busy) begin
          ck_acc_d = ck_acc_q + pstore[ck_idx_q];
          ck_idx_d = ck_idx_q + 5'h01;
          if (ck_idx_q == 5'(sc_cmd_pkg::PS_DEPTH - 1)) begin
            ck_sum_d = ck_acc_q + pstore[ck_idx_q];
            state_d  = sc_cmd_pkg::ST_IDLE;
            if (pend_q) begin
              pend_d      = 1'b0;
              rsp_valid_d = 1'b1;
              rsp_data_d  = ck_acc_q + pstore[ck_idx_q];
            end
          end
        end
        // R14 read back through the port
        if (rd) begin
          if (ck_busy && (cmd_code == sc_cmd_pkg::CMD_VENDOR) &&
              (last_sub_q == sc_cmd_pkg::SUB_CKSUM)) begin
            pend_d = 1'b1;
          end else begin
            rsp_valid_d = 1'b1;
            rsp_data_d  = read_word;
          end
        end
        if (vwr) begin
          if (key_stage_q) begin
            // R12 second key word
            key_stage_d = 1'b0;
            if (cmd_wdata == sc_cmd_pkg::KEY_WORD2) begin
              sealed_d = 1'b0;
            end else begin
              // R13 lock out after failure
              lock_d = sc_cmd_pkg::lock_cnt_t'(UNSEAL_WAIT_CYC);
            end
          end else if (sealed_q && (cmd_wdata == sc_cmd_pkg::KEY_WORD1)) begin
            // R13 attempts refused while locked
            key_stage_d = (lock_q == '0);
          end else if (life_arm_q) begin
            // R23 value word sets both
            life_d     = cmd_wdata[0];
            life_arm_d = 1'b0;
          end else begin
            case (cmd_wdata)
              sc_cmd_pkg::SUB_DEV_TYPE, sc_cmd_pkg::SUB_FW_REV,
              sc_cmd_pkg::SUB_HW_REV: begin
                last_sub_d = cmd_wdata;
              end
              // R5 arm lifetime and balancing
              sc_cmd_pkg::SUB_LIFE_BAL: begin
                last_sub_d = cmd_wdata;
                life_arm_d = 1'b1;
              end
              // R2 checksum only when unsealed
              sc_cmd_pkg::SUB_CKSUM: begin
                if (unsealed && !ck_busy) begin
                  last_sub_d = cmd_wdata;
                  state_d    = sc_cmd_pkg::ST_CKSUM;
                  ck_idx_d   = 5'h00;
                  ck_acc_d   = 16'h0000;
                end
              end
              // R4 seal when unsealed
              sc_cmd_pkg::SUB_SEAL: begin
                if (unsealed) begin
                  sealed_d = 1'b1;
                end
              end
              // R9 pin drive gated by seal
              // R6 alarm pin
              sc_cmd_pkg::SUB_ALARM_SET: if (unsealed) alarm_d = 1'b1;
              sc_cmd_pkg::SUB_ALARM_CLR: if (unsealed) alarm_d = 1'b0;
              // R7 charge level 0
              sc_cmd_pkg::SUB_CL0_SET:   if (unsealed) cl0_d = 1'b1;
              sc_cmd_pkg::SUB_CL0_CLR:   if (unsealed) cl0_d = 1'b0;
              // R8 learn load pin
              sc_cmd_pkg::SUB_LL_SET:    if (unsealed) ll_d = 1'b1;
              sc_cmd_pkg::SUB_LL_CLR:    if (unsealed) ll_d = 1'b0;
              // R9 calibration entry
              sc_cmd_pkg::SUB_CAL:       if (unsealed) cal_d = 1'b1;
              // R10 full reset, clock held
              sc_cmd_pkg::SUB_RESET: begin
                if (unsealed && !ck_busy) begin
                  state_d     = sc_cmd_pkg::ST_RST_HOLD;
                  hold_d      = sc_cmd_pkg::hold_cnt_t'(RESET_HOLD_CYC);
                  scl_oe_d    = 1'b1;
                  sealed_d    = sc_cmd_pkg::SEALED_RST;
                  {alarm_d, cl0_d, cl1_d, ll_d, life_d} = 5'h00;
                  {life_arm_d, cal_d, dis_d, key_stage_d, pend_d} = 5'h00;
                  last_sub_d  = 16'h0000;
                end
              end
              default: begin
                // R24 charge level 1 codes
                if (unsealed && (cmd_wdata == CL1_SET_CODE)) begin
                  cl1_d = 1'b1;
                end else if (unsealed && (cmd_wdata == CL1_CLR_CODE)) begin
                  cl1_d = 1'b0;
                end
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= sc_cmd_pkg::ST_IDLE;
      {sealed_q, chk_q} <= {sc_cmd_pkg::SEALED_RST, 1'b1};
      {alarm_q, cl0_q, cl1_q, ll_q, life_q, life_arm_q, cal_q} <= 7'h00;
      {dis_q, key_stage_q, pend_q, rsp_valid_q, scl_oe_q} <= 5'h00;
      {lock_q, hold_q, last_sub_q, ck_idx_q} <= '0;
      {ck_acc_q, ck_sum_q, rsp_data_q} <= '0;
    end else begin
      state_q <= state_d;
      {sealed_q, chk_q, alarm_q, cl0_q, cl1_q, ll_q} <=
        {sealed_d, chk_d, alarm_d, cl0_d, cl1_d, ll_d};
      {life_q, life_arm_q, cal_q, dis_q, key_stage_q, pend_q} <=
        {life_d, life_arm_d, cal_d, dis_d, key_stage_d, pend_d};
      {rsp_valid_q, scl_oe_q, lock_q, hold_q, last_sub_q} <=
        {rsp_valid_d, scl_oe_d, lock_d, hold_d, last_sub_d};
      {ck_idx_q, ck_acc_q, ck_sum_q, rsp_data_q} <=
        {ck_idx_d, ck_acc_d, ck_sum_d, rsp_data_d};
    end
  end

  // The line is only ever pulled low; its level is not needed here.
  logic scl_unused;
  assign scl_unused = scl_in;

  assign rsp_valid            = rsp_valid_q;
  assign rsp_data             = rsp_data_q;
  assign scl_out              = 1'b0;
  assign scl_oe               = scl_oe_q;
  assign alarm_out            = alarm_q;
  assign charge_level_select0 = cl0_q;
  assign charge_level_select1 = cl1_q;
  assign learn_load_drive     = ll_q;
  // R5 one enable drives both
  assign lifetime_log_enable  = life_q;
  assign balance_enable       = life_q;
  assign balance_discharge    = dis_q;
  assign cal_mode             = cal_q;
  assign sealed               = sealed_q;

endmodule : supercap_cmd

// [testbench/supercap_cmd_asserts.sv]
module supercap_cmd_chk #(
  parameter int RESET_HOLD_CYC = 10
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Word commands
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  // Pins and inputs
  input wire logic        scl_oe,
  input wire logic [15:0] temp_internal,
  input wire logic        temp_source_sel_hi,
  input wire logic        temp_source_sel_lo,
  input wire logic        alarm_out,
  input wire logic        sealed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic        vw;
  logic        rd;
  logic [15:0] hold_d;
  logic [15:0] hold_q;
  // Commands in the reset hold are dropped, so they are left out here.
  assign vw = cmd_valid && cmd_write && cmd_code == 8'h00 && !scl_oe;
  assign rd = cmd_valid && !cmd_write && !scl_oe;
  always_comb hold_d = scl_oe ? hold_q + 16'h0001 : 16'h0000;
  always_ff @(posedge core_clk) hold_q <= rst ? 16'h0000 : hold_d;
  chk_alarm_set: assert property (
    vw && cmd_wdata == 16'h0030 && !sealed |=> alarm_out)
    else $error("alarm not raised");
  chk_alarm_clear: assert property (
    vw && cmd_wdata == 16'h0031 && !sealed |=> !alarm_out)
    else $error("alarm not cleared");
  chk_sealed_ignore: assert property (
    vw && sealed && cmd_wdata == 16'h0030 |=> $stable(alarm_out))
    else $error("pin moved while sealed");
  chk_seal_sets: assert property (
    vw && cmd_wdata == 16'h0020 && !sealed |=> sealed)
    else $error("seal not taken");
  chk_temp_answer: assert property (
    rd && cmd_code == 8'h08 && !temp_source_sel_hi && !temp_source_sel_lo
    |=> rsp_valid && rsp_data == $past(temp_internal))
    else $error("wrong temperature answer");
  chk_volt_limit: assert property (
    rd && cmd_code == 8'h09 |=> rsp_valid && rsp_data <= 16'd20000)
    else $error("voltage above range");
  chk_reset_hold: assert property (
    vw && cmd_wdata == 16'h0041 && !sealed |=> scl_oe && sealed)
    else $error("reset did not hold clock line");
  chk_hold_len: assert property (
    $fell(scl_oe) |-> hold_q == RESET_HOLD_CYC + 1)
    else $error("clock hold length wrong");
endmodule : supercap_cmd_chk

bind supercap_cmd supercap_cmd_chk #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) chk_u (
  .core_clk, .rst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
  .rsp_valid, .rsp_data, .scl_oe, .temp_internal, .temp_source_sel_hi,
  .temp_source_sel_lo, .alarm_out, .sealed);

// [testbench/host_model.sv]
module host_model (
  // Clock
  input  wire logic        core_clk,
  // Word commands
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic      [7:0]  cmd_code,
  output logic      [15:0] cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  // Clock line
  input  wire logic        scl_oe,
  output logic             scl_line
);
  timeunit 1ns;
  timeprecision 1ns;
  assign scl_line = scl_oe ? 1'b0 : 1'b1;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'hFF;
    cmd_wdata = 16'hFFFF;
  end
  // Idle fields carry inverted garbage so stale values never pass.
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_wdata <= ~d;
  endtask : xfer
  task automatic rd(input logic [7:0] c, output logic [15:0] q);
    q = 'x;
    xfer(1'b0, c, 16'h0000);
    for (int n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (rsp_valid === 1'b1) begin
        q = rsp_data;
        break;
      end
    end
  endtask : rd
endmodule : host_model

// [testbench/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
  int n_fail = 0, comparisons = 0, cyc = 0;
  logic core_clk = 1'b0, rst = 1'b1, ps_wr_en = 1'b0;
  logic cmd_valid, cmd_write, rsp_valid, scl_line, scl_out, scl_oe;
  logic [7:0] cmd_code;
  logic [4:0] ps_wr_addr = 5'h00;
  logic [15:0] cmd_wdata, rsp_data, q, sum, ps_wr_data = 16'h0000;
  logic [15:0] temp_internal = 16'h0BB8, temp_ext_a = 16'h0C00;
  logic [15:0] temp_ext_b = 16'h0D00, stack_top_sense_input = 16'h61A8;
  logic [15:0] current_raw = 16'hFFF6, deadband_ma = 16'h000A;
  logic [15:0] esr_mohm = 16'h0123, remaining_cap = 16'h00C7;
  logic [15:0] full_cap = 16'h00C8, present_cap = 16'h0032;
  logic [15:0] initial_cap_value = 16'h00C8;
  logic [15:0] target_charge_voltage = 16'h1000;
  logic temp_source_sel_hi = 1'b0, temp_source_sel_lo = 1'b0;
  logic hold_at_99_enable = 1'b1, charge_term = 1'b0;
  logic alarm_out, charge_level_select0, charge_level_select1, cal_mode;
  logic learn_load_drive, lifetime_log_enable, balance_enable;
  logic balance_discharge, sealed;
  supercap_cmd #(.UNSEAL_WAIT_CYC(50), .RESET_HOLD_CYC(10)) dut_u (
    .core_clk, .rst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .rsp_valid, .rsp_data, .scl_in(scl_line), .scl_out, .scl_oe, .ps_wr_en,
    .ps_wr_addr, .ps_wr_data, .temp_internal, .temp_ext_a, .temp_ext_b,
    .temp_source_sel_hi, .temp_source_sel_lo, .stack_top_sense_input,
    .current_raw, .deadband_ma, .esr_mohm, .remaining_cap, .full_cap,
    .present_cap, .initial_cap_value, .hold_at_99_enable, .charge_term,
    .target_charge_voltage, .alarm_out, .charge_level_select0,
    .charge_level_select1, .learn_load_drive, .lifetime_log_enable,
    .balance_enable, .balance_discharge, .cal_mode, .sealed);
  host_model host_u (.core_clk, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_wdata, .rsp_valid, .rsp_data, .scl_oe, .scl_line);
  always #25 core_clk = ~core_clk;
  task automatic wr(input logic [15:0] d);
    host_u.xfer(1'b1, 8'h00, d);
  endtask : wr
  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic t_gate;
    `CHK(sealed, 1'b1)
    wr(16'h0030);
    @(posedge core_clk);
    `CHK(alarm_out, 1'b0)
    wr(sc_cmd_pkg::KEY_WORD1);
    wr(sc_cmd_pkg::KEY_WORD2);
    @(posedge core_clk);
    `CHK(sealed, 1'b0)
  endtask : t_gate
  task automatic t_pins;
    logic [15:0] c [8] = '{16'h0030, 16'h0032, 16'h0034, 16'h0037,
                           16'h0031, 16'h0033, 16'h0035, 16'h0038};
    logic [3:0] e [8] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'hE, 4'hC, 4'h8, 4'h0};
    logic [3:0] p;
    for (int i = 0; i < 8; i++) begin
      wr(c[i]);
      @(posedge core_clk);
      p = {learn_load_drive, charge_level_select1, charge_level_select0,
           alarm_out};
      `CHK(p, e[i])
    end
    wr(16'h0040);
    @(posedge core_clk);
    `CHK(cal_mode, 1'b1)
  endtask : t_pins
  task automatic t_life;
    for (int v = 1; v >= 0; v--) begin
      wr(16'h0021);
      wr(16'(v));
      @(posedge core_clk);
      `CHK({lifetime_log_enable, balance_enable}, {2{v[0]}})
    end
  endtask : t_life
  task automatic t_cksum;
    sum = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk);
      ps_wr_en <= 1'b1;
      ps_wr_addr <= 5'(i);
      ps_wr_data <= 16'(16'h0101 * i + 16'h00A0);
      sum = sum + 16'(16'h0101 * i + 16'h00A0);
    end
    @(posedge core_clk);
    ps_wr_en <= 1'b0;
    wr(16'h0004);
    host_u.rd(8'h08, q);
    `CHK(q, temp_internal)
    host_u.rd(8'h00, q);
    `CHK(q, sum)
    wr(16'h0003);
    host_u.rd(8'h00, q);
    `CHK(q, 16'h00BF)
    wr(16'h0002);
    host_u.rd(8'h00, q);
    `CHK(q, sc_cmd_pkg::FW_REV_ID)
    wr(16'h0001);
    host_u.rd(8'h00, q);
    `CHK(q, sc_cmd_pkg::DEV_TYPE_ID)
  endtask : t_cksum
  task automatic t_meas;
    logic [15:0] t [4] = '{16'h0BB8, 16'h0C00, 16'h0D00, 16'h0D00};
    for (int s = 0; s < 4; s++) begin
      {temp_source_sel_hi, temp_source_sel_lo} <= 2'(s);
      host_u.rd(8'h08, q);
      `CHK(q, t[s])
    end
    host_u.rd(8'h09, q);
    `CHK(q, 16'd20000)
    host_u.rd(8'h0A, q);
    `CHK(q, 16'h0000)
    current_raw <= 16'hFFF5;
    host_u.rd(8'h0A, q);
    `CHK(q, 16'hFFF5)
    host_u.rd(8'h0B, q);
    `CHK(q, 16'h0123)
    host_u.rd(8'h0E, q);
    `CHK(q, 16'd25)
    host_u.rd(8'h0D, q);
    `CHK(q, 16'd99)
    charge_term <= 1'b1;
    repeat (60) @(posedge core_clk);
    host_u.rd(8'h0D, q);
    `CHK(q, 16'd100)
    {hold_at_99_enable, charge_term} <= 2'b00;
    repeat (60) @(posedge core_clk);
    host_u.rd(8'h0D, q);
    `CHK(q, 16'd100)
    {remaining_cap, full_cap} <= {16'h0001, 16'h0003};
    repeat (60) @(posedge core_clk);
    host_u.rd(8'h0D, q);
    `CHK(q, 16'd34)
    {remaining_cap, full_cap} <= {16'hFFFF, 16'hFFFF};
    repeat (60) @(posedge core_clk);
    host_u.rd(8'h0D, q);
    `CHK(q, 16'h0064)
  endtask : t_meas
  task automatic t_lock;
    wr(16'h0020);
    wr(sc_cmd_pkg::KEY_WORD1);
    wr(16'h0BAD);
    wr(sc_cmd_pkg::KEY_WORD1);
    wr(sc_cmd_pkg::KEY_WORD2);
    @(posedge core_clk);
    `CHK(sealed, 1'b1)
    repeat (60) @(posedge core_clk);
    wr(sc_cmd_pkg::KEY_WORD1);
    wr(sc_cmd_pkg::KEY_WORD2);
    @(posedge core_clk);
    `CHK(sealed, 1'b0)
  endtask : t_lock
  task automatic t_rst;
    wr(16'h0030);
    wr(16'h0041);
    @(posedge core_clk);
    `CHK({scl_out, scl_line, alarm_out, sealed}, 4'h1)
    for (int n = 0; n < 30 && scl_oe !== 1'b0; n++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    `CHK({scl_line, balance_discharge}, 2'h3)
  endtask : t_rst
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_gate();
    t_pins();
    t_life();
    t_cksum();
    t_meas();
    t_lock();
    t_rst();
    end_of_test();
  end
endmodule : tb
